/* core/spfd_pkg.sv */
// spfd_pkg: register map, field layout, reset values and timing constants
// for the stall prevention and frequency detection supervisor.
// assumes a single 250 MHz clock domain and a plain strobe register port.
`default_nettype none

package spfd_pkg;

	// word-aligned register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_ACCEL = 8'h04;
	localparam logic [7:0] ADDR_DECEL = 8'h08;
	localparam logic [7:0] ADDR_RUN = 8'h0C;
	localparam logic [7:0] ADDR_FDET = 8'h10;
	localparam logic [7:0] ADDR_LOSS = 8'h14;
	localparam logic [7:0] ADDR_LIMIT = 8'h18;
	localparam logic [7:0] ADDR_BASE = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;

	// control register bit positions
	localparam int CTRL_ACCEL_EN = 0;
	localparam int CTRL_DECEL_EN = 1;
	localparam int CTRL_RUN_MODE = 2;
	localparam int CTRL_LOSS_ACT = 4;
	localparam int CTRL_HV_CLASS = 5;
	localparam int CTRL_ANALOG_LVL = 6;
	localparam int CTRL_DUTY = 7;
	localparam int CTRL_WIDTH = 8;
	// accel stall enable, decel stall enable, run mode 1
	localparam logic [7:0] CTRL_RESET = 8'h07;

	// currents in percent of rated, frequency in 0.1 Hz, voltage in volts
	localparam logic [7:0] ACCEL_LVL_MAX = 8'h96;
	localparam logic [7:0] ACCEL_FLOOR_MAX = 8'h64;
	localparam logic [7:0] ACCEL_FLOOR_RESET = 8'h32;
	localparam logic [8:0] DECEL_V_MIN = 9'h14A;
	localparam logic [8:0] DECEL_V_MAX = 9'h19A;
	localparam logic [8:0] DECEL_V_RESET = 9'h18B;
	localparam logic [7:0] RUN_LVL_MIN = 8'h1E;
	localparam logic [7:0] RUN_LVL_MAX = 8'h96;
	localparam logic [15:0] FDET_LVL_RESET = 16'h012C;
	localparam logic [7:0] FDET_W_MIN = 8'h01;
	localparam logic [7:0] FDET_W_RESET = 8'h14;
	localparam logic [9:0] FALLBACK_MAX = 10'h3E8;
	localparam logic [9:0] FALLBACK_RESET = 10'h320;
	localparam logic [8:0] LOSS_T_MIN = 9'h014;
	localparam logic [8:0] LOSS_T_MAX = 9'h190;
	localparam logic [8:0] LOSS_T_RESET = 9'h014;
	localparam logic [15:0] MAXF_RESET = 16'h0258;
	localparam logic [15:0] BASEF_RESET = 16'h0258;
	localparam logic [15:0] RUN_MIN_FREQ = 16'h003C;

	// hysteresis figures in percent
	localparam logic [7:0] ACCEL_RELEASE_PCT = 8'h55;
	localparam logic [7:0] RUN_RELEASE_DROP = 8'h02;
	localparam logic [7:0] LOSS_RATIO_PCT = 8'h5A;

	// timing: 250 MHz clock
	localparam int CLK_MHZ = 250;
	localparam int RUN_RECOVER_MS = 100;
	localparam int MS_CYCLES = CLK_MHZ * 1000;
	localparam int RUN_RECOVER_CYCLES = RUN_RECOVER_MS * MS_CYCLES;

	// ramp phase reported by the ramp generator
	typedef enum logic [1:0] {
		SPFD_IDLE = 2'b00,
		SPFD_ACCEL = 2'b01,
		SPFD_RUN = 2'b10,
		SPFD_DECEL = 2'b11
	} spfd_phase_e;

endpackage

`default_nettype wire

/* core/spfd_core.sv */
// spfd_core: stall prevention supervisor for accel, run and decel phases,
// frequency agree/detect outputs and frequency command loss handling.
// assumes synchronous inputs on mclk_i, a ramp generator that obeys the
// hold/decel requests, and software access over a plain strobe port.
//
// Summary of operation
// R1: accel stall current level programmable from 0 to 150 percent.
// R2: constant power range lowers accel level, never under the floor limit.
// R3: decel stall enabled holds frequency while bus voltage above level.
// R4: decel stall disabled ramps down at set time regardless of voltage.
// R5: decel voltage level 330 to 410 volts, default 395, doubled high class.
// R6: run stall stays inactive below 6 Hz output frequency.
// R7: run mode 1 decelerates on deceleration time one above run level.
// R8: reaccelerate only after current under level minus 2 for 100 ms.
// R9: run mode 2 equals mode 1 but uses deceleration time two.
// R10: run mode 0 tracks the command with no current reduction.
// R11: run stall level 30 to 150 percent, default from duty rating.
// R12: analog level option uses the smaller of setting and analog input.
// R13: detect level default 30.0 Hz, capped; width 0.1 to 25.5 Hz.
// R14: width alone drives agree; level and width drive user agree, detect 1 and detect 2.
// R15: command loss when command drops under 90 percent within window.
// R16: loss output asserts while a command loss is detected.
// R17: loss action 1 runs at fallback frequency until command restored.
// R18: loss action 0 keeps following the frequency command.
// R19: accel halts above level, resumes when current 15 percent below.
// R20: fallback frequency is 0.0 to 100.0 percent of maximum frequency.
// R21: accel and decel supervisors act only in their own ramp phase; run stall triggers only in run.
`default_nettype none

module spfd_core #(
	parameter int RECOVER_CYCLES = spfd_pkg::RUN_RECOVER_CYCLES,
	parameter int MS_TICK_CYCLES = spfd_pkg::MS_CYCLES,
	parameter logic [7:0] LVL_DEFAULT_ND = 8'h78,
	parameter logic [7:0] LVL_DEFAULT_HD = 8'h96
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// measurements and ramp state
	input wire logic [1:0] ramp_phase_i,
	input wire logic [15:0] out_freq_i,
	input wire logic [15:0] freq_cmd_i,
	input wire logic [7:0] out_current_i,
	input wire logic [9:0] bus_voltage_i,
	input wire logic [7:0] analog_level_i,
	// requests to the ramp generator
	output logic [15:0] freq_target_o,
	output logic accel_hold_o,
	output logic decel_hold_o,
	output logic run_decel_o,
	output logic decel_time_two_o,
	// multi-function output sources
	output logic freq_agree_o,
	output logic user_freq_agree_o,
	output logic freq_detect1_o,
	output logic freq_detect2_o,
	output logic cmd_loss_o
);

	function automatic logic [15:0] clamp16(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic logic [15:0] absdiff(input logic [15:0] a,
		input logic [15:0] b);
		absdiff = (a > b) ? a - b : b - a;
	endfunction

	// software state
	logic [spfd_pkg::CTRL_WIDTH-1:0] ctrl;
	logic [7:0] accel_stall_current_level;
	logic [7:0] accel_stall_floor_limit;
	logic [8:0] decel_stall_voltage_level;
	logic [7:0] run_stall_current_level;
	logic [15:0] freq_detect_level;
	logic [7:0] freq_detect_width;
	logic [9:0] cmd_loss_fallback_freq;
	logic [8:0] cmd_loss_detect_time;
	logic [15:0] max_output_freq;
	logic [15:0] freq_cmd_upper_limit;
	logic [15:0] base_freq;

	logic accel_stall_enable;
	logic decel_stall_enable;
	logic [1:0] run_stall_mode;
	logic cmd_loss_action_select;
	logic high_voltage_class;
	logic analog_level_enable;
	logic duty_rating_select;
	logic [7:0] wr_byte;
	logic [15:0] wr_half;

	assign accel_stall_enable = ctrl[spfd_pkg::CTRL_ACCEL_EN];
	assign decel_stall_enable = ctrl[spfd_pkg::CTRL_DECEL_EN];
	assign run_stall_mode = ctrl[spfd_pkg::CTRL_RUN_MODE +: 2];
	assign cmd_loss_action_select = ctrl[spfd_pkg::CTRL_LOSS_ACT];
	assign high_voltage_class = ctrl[spfd_pkg::CTRL_HV_CLASS];
	assign analog_level_enable = ctrl[spfd_pkg::CTRL_ANALOG_LVL];
	assign duty_rating_select = ctrl[spfd_pkg::CTRL_DUTY];
	assign wr_byte = reg_wdata_i[7:0];
	assign wr_half = reg_wdata_i[15:0];

	// control register; run mode 3 is not a setting and folds to 0
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			ctrl <= spfd_pkg::CTRL_RESET;
		end else if (reg_wr_i && reg_addr_i == spfd_pkg::ADDR_CTRL) begin
			ctrl <= wr_byte;
			if (wr_byte[spfd_pkg::CTRL_RUN_MODE +: 2] == 2'b11) begin
				ctrl[spfd_pkg::CTRL_RUN_MODE +: 2] <= 2'b00;
			end
		end
	end

	// current levels; writing duty rating reloads its dependent defaults
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			accel_stall_current_level <= LVL_DEFAULT_ND;
			accel_stall_floor_limit <= spfd_pkg::ACCEL_FLOOR_RESET;
			run_stall_current_level <= LVL_DEFAULT_ND;
		end else if (reg_wr_i) begin
			if (reg_addr_i == spfd_pkg::ADDR_CTRL &&
				wr_byte[spfd_pkg::CTRL_DUTY] != duty_rating_select) begin
				accel_stall_current_level <= wr_byte[spfd_pkg::CTRL_DUTY] ?
					LVL_DEFAULT_HD : LVL_DEFAULT_ND;
				run_stall_current_level <= wr_byte[spfd_pkg::CTRL_DUTY] ?
					LVL_DEFAULT_HD : LVL_DEFAULT_ND;
			end
			// R1: accel level clamp
			if (reg_addr_i == spfd_pkg::ADDR_ACCEL) begin
				accel_stall_current_level <= 8'(clamp16({8'h00, wr_byte},
					16'h0000, {8'h00, spfd_pkg::ACCEL_LVL_MAX}));
				accel_stall_floor_limit <= 8'(clamp16({8'h00, wr_half[15:8]},
					16'h0000, {8'h00, spfd_pkg::ACCEL_FLOOR_MAX}));
			end
			// R11: run level clamp
			if (reg_addr_i == spfd_pkg::ADDR_RUN) begin
				run_stall_current_level <= 8'(clamp16({8'h00, wr_byte},
					{8'h00, spfd_pkg::RUN_LVL_MIN},
					{8'h00, spfd_pkg::RUN_LVL_MAX}));
			end
		end
	end

	// voltage, detection, loss and frequency limit settings
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			decel_stall_voltage_level <= spfd_pkg::DECEL_V_RESET;
			freq_detect_level <= spfd_pkg::FDET_LVL_RESET;
			freq_detect_width <= spfd_pkg::FDET_W_RESET;
			cmd_loss_fallback_freq <= spfd_pkg::FALLBACK_RESET;
			cmd_loss_detect_time <= spfd_pkg::LOSS_T_RESET;
			max_output_freq <= spfd_pkg::MAXF_RESET;
			freq_cmd_upper_limit <= spfd_pkg::MAXF_RESET;
			base_freq <= spfd_pkg::BASEF_RESET;
		end else if (reg_wr_i) begin
			unique case (reg_addr_i)
				// R5: decel voltage range
				spfd_pkg::ADDR_DECEL: begin
					decel_stall_voltage_level <= 9'(clamp16(
						{7'h00, reg_wdata_i[8:0]},
						{7'h00, spfd_pkg::DECEL_V_MIN},
						{7'h00, spfd_pkg::DECEL_V_MAX}));
				end
				// R13: width floor of 0.1 Hz
				spfd_pkg::ADDR_FDET: begin
					freq_detect_level <= wr_half;
					freq_detect_width <= 8'(clamp16({8'h00, reg_wdata_i[23:16]},
						{8'h00, spfd_pkg::FDET_W_MIN}, 16'h00FF));
				end
				// R20: fallback up to 100.0 percent
				spfd_pkg::ADDR_LOSS: begin
					cmd_loss_fallback_freq <= 10'(clamp16({6'h00, reg_wdata_i[9:0]},
						16'h0000, {6'h00, spfd_pkg::FALLBACK_MAX}));
					cmd_loss_detect_time <= 9'(clamp16(
						{7'h00, reg_wdata_i[24:16]},
						{7'h00, spfd_pkg::LOSS_T_MIN},
						{7'h00, spfd_pkg::LOSS_T_MAX}));
				end
				spfd_pkg::ADDR_LIMIT: begin
					max_output_freq <= wr_half;
					freq_cmd_upper_limit <= reg_wdata_i[31:16];
				end
				spfd_pkg::ADDR_BASE: begin
					base_freq <= wr_half;
				end
				default: begin
				end
			endcase
		end
	end

	// acceleration stall supervisor
	logic [7:0] accel_eff_level;
	logic [23:0] accel_scaled;
	logic accel_hold;

	// R2: level * base / fout above base, floored
	always_comb begin
		accel_scaled = 24'h000000;
		accel_eff_level = accel_stall_current_level;
		if (out_freq_i > base_freq && out_freq_i != 16'h0000) begin
			accel_scaled = ({16'h0000, accel_stall_current_level} *
				{8'h00, base_freq}) / {8'h00, out_freq_i};
			accel_eff_level = accel_scaled[7:0];
			if (accel_scaled[7:0] < accel_stall_floor_limit) begin
				accel_eff_level = accel_stall_floor_limit;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			accel_hold <= 1'b0;
		// R21: only while ramping up
		end else if (!accel_stall_enable ||
			ramp_phase_i != spfd_pkg::SPFD_ACCEL) begin
			accel_hold <= 1'b0;
		// R19: halt above level
		end else if (out_current_i > accel_eff_level) begin
			accel_hold <= 1'b1;
		// R19: resume 15 percent below
		end else if ({8'h00, out_current_i} * 16'd100 <
			{8'h00, accel_eff_level} * {8'h00, spfd_pkg::ACCEL_RELEASE_PCT}) begin
			accel_hold <= 1'b0;
		end
	end

	// deceleration stall supervisor
	logic [9:0] decel_threshold;
	logic decel_hold;

	// R5: doubled for high voltage class
	assign decel_threshold = high_voltage_class ?
		{decel_stall_voltage_level, 1'b0} : {1'b0, decel_stall_voltage_level};

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			decel_hold <= 1'b0;
		// R4: disabled ignores bus voltage
		end else if (!decel_stall_enable ||
			ramp_phase_i != spfd_pkg::SPFD_DECEL) begin
			decel_hold <= 1'b0;
		// R3: freeze above level, resume below
		end else begin
			decel_hold <= bus_voltage_i > decel_threshold;
		end
	end

	// run stall supervisor
	logic [7:0] run_eff_level;
	logic run_active;
	logic run_reduce;
	logic run_time_two;
	logic [$clog2(RECOVER_CYCLES+1)-1:0] recover_count;

	// R12: smaller of setting and analog input
	assign run_eff_level = (analog_level_enable &&
		analog_level_i < run_stall_current_level) ?
		analog_level_i : run_stall_current_level;

	// R6: inactive below 6 Hz; R10: mode 0 never reduces
	assign run_active = run_stall_mode != 2'b00 &&
		out_freq_i >= spfd_pkg::RUN_MIN_FREQ;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			run_reduce <= 1'b0;
			run_time_two <= 1'b0;
			recover_count <= '0;
		end else if (!run_active) begin
			run_reduce <= 1'b0;
			recover_count <= '0;
		// R21: trigger only at constant speed
		end else if (!run_reduce) begin
			recover_count <= '0;
			if (ramp_phase_i == spfd_pkg::SPFD_RUN &&
				out_current_i > run_eff_level) begin
				run_reduce <= 1'b1;
				// R7: time one; R9: mode 2 uses time two
				run_time_two <= run_stall_mode == 2'b10;
			end
		// R8: level minus 2 held for 100 ms
		end else if ({1'b0, out_current_i} + {1'b0, spfd_pkg::RUN_RELEASE_DROP}
			< {1'b0, run_eff_level}) begin
			if (recover_count == RECOVER_CYCLES[$bits(recover_count)-1:0] -
				1'b1) begin
				run_reduce <= 1'b0;
				recover_count <= '0;
			end else begin
				recover_count <= recover_count + 1'b1;
			end
		end else begin
			recover_count <= '0;
		end
	end

	// frequency detection
	logic [15:0] det_level;
	logic [15:0] det_cap;
	logic [15:0] width16;
	logic det1;
	logic det2;
	logic agree;
	logic user_agree;

	// R13: level capped by max frequency and upper limit
	assign det_cap = (max_output_freq < freq_cmd_upper_limit) ?
		max_output_freq : freq_cmd_upper_limit;
	assign det_level = (freq_detect_level > det_cap) ? det_cap :
		freq_detect_level;
	assign width16 = {8'h00, freq_detect_width};

	// R14: agree, user agree, detect 1 and detect 2 with width band
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			agree <= 1'b0;
			user_agree <= 1'b0;
			det1 <= 1'b0;
			det2 <= 1'b0;
		end else begin
			agree <= ramp_phase_i != spfd_pkg::SPFD_IDLE &&
				absdiff(out_freq_i, freq_target_o) <= width16;
			user_agree <= absdiff(out_freq_i, det_level) <= width16 &&
				absdiff(out_freq_i, freq_target_o) <= width16;
			if (out_freq_i >= det_level) begin
				det1 <= 1'b1;
			end else if ({1'b0, out_freq_i} + {1'b0, width16} <
				{1'b0, det_level}) begin
				det1 <= 1'b0;
			end
			if (out_freq_i <= det_level) begin
				det2 <= 1'b1;
			end else if ({1'b0, out_freq_i} >
				{1'b0, det_level} + {1'b0, width16}) begin
				det2 <= 1'b0;
			end
		end
	end

	// command loss detection
	logic [$clog2(MS_TICK_CYCLES+1)-1:0] ms_count;
	logic [8:0] window_ms;
	logic [15:0] window_ref;
	logic [15:0] loss_ref;
	logic cmd_loss;
	logic [25:0] fallback_prod;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			ms_count <= '0;
			window_ms <= 9'h000;
			window_ref <= 16'h0000;
			loss_ref <= 16'h0000;
			cmd_loss <= 1'b0;
		end else begin
			if (ms_count == MS_TICK_CYCLES[$bits(ms_count)-1:0] - 1'b1) begin
				ms_count <= '0;
				if (window_ms >= cmd_loss_detect_time - 9'h001) begin
					window_ms <= 9'h000;
					window_ref <= freq_cmd_i;
					// R15: below 90 percent within window
					if (!cmd_loss && {4'h0, freq_cmd_i} * 20'd100 <
						{4'h0, window_ref} * {12'h000, spfd_pkg::LOSS_RATIO_PCT}) begin
						cmd_loss <= 1'b1;
						loss_ref <= window_ref;
					end
				end else begin
					window_ms <= window_ms + 9'h001;
				end
			end else begin
				ms_count <= ms_count + 1'b1;
			end
			// restored once back at 90 percent of the lost value
			if (cmd_loss && {4'h0, freq_cmd_i} * 20'd100 >=
				{4'h0, loss_ref} * {12'h000, spfd_pkg::LOSS_RATIO_PCT}) begin
				cmd_loss <= 1'b0;
			end
		end
	end

	// R20: percent of maximum output frequency, 0.1 percent steps
	assign fallback_prod = {10'h000, max_output_freq} *
		{16'h0000, cmd_loss_fallback_freq} / 26'd1000;

	// target frequency handed to the ramp generator
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			freq_target_o <= 16'h0000;
		// R17: fallback while loss persists
		end else if (cmd_loss && cmd_loss_action_select) begin
			freq_target_o <= fallback_prod[15:0];
		// R18: follow the command otherwise
		end else begin
			freq_target_o <= freq_cmd_i;
		end
	end

	// register read port, data one cycle after the strobe
	always_ff @(posedge mclk_i) begin
		if (reset_i || !reg_rd_i) begin
			reg_rdata_o <= 32'h00000000;
		end else begin
			unique case (reg_addr_i)
				spfd_pkg::ADDR_CTRL: reg_rdata_o <= {24'h000000, ctrl};
				spfd_pkg::ADDR_ACCEL: reg_rdata_o <= {16'h0000,
					accel_stall_floor_limit, accel_stall_current_level};
				spfd_pkg::ADDR_DECEL: reg_rdata_o <= {23'h000000,
					decel_stall_voltage_level};
				spfd_pkg::ADDR_RUN: reg_rdata_o <= {24'h000000,
					run_stall_current_level};
				spfd_pkg::ADDR_FDET: reg_rdata_o <= {8'h00, freq_detect_width,
					freq_detect_level};
				spfd_pkg::ADDR_LOSS: reg_rdata_o <= {7'h00, cmd_loss_detect_time,
					6'h00, cmd_loss_fallback_freq};
				spfd_pkg::ADDR_LIMIT: reg_rdata_o <= {freq_cmd_upper_limit,
					max_output_freq};
				spfd_pkg::ADDR_BASE: reg_rdata_o <= {16'h0000, base_freq};
				spfd_pkg::ADDR_STATUS: reg_rdata_o <= {23'h000000,
					cmd_loss, det2, det1, user_agree,
					agree, run_time_two, run_reduce, decel_hold, accel_hold};
				default: reg_rdata_o <= 32'h00000000;
			endcase
		end
	end

	assign accel_hold_o = accel_hold;
	assign decel_hold_o = decel_hold;
	assign run_decel_o = run_reduce;
	assign decel_time_two_o = run_time_two;
	assign freq_agree_o = agree;
	assign user_freq_agree_o = user_agree;
	assign freq_detect1_o = det1;
	assign freq_detect2_o = det2;
	// R16: loss output follows detection
	assign cmd_loss_o = cmd_loss;

endmodule

`default_nettype wire

/* verif/spfd_monitor.sv */
// spfd_monitor: port checks for the stall and frequency supervisor.
// assumes binding into spfd_core; it snoops control writes itself.
`default_nettype none
module spfd_monitor #(
	parameter int RECOVER_CYCLES = 20
) (
	// clock, reset and register port
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	// ramp state
	input wire logic [1:0] ramp_phase_i,
	input wire logic [15:0] out_freq_i,
	input wire logic [15:0] freq_cmd_i,
	// supervisor outputs
	input wire logic [15:0] freq_target_o,
	input wire logic accel_hold_o,
	input wire logic decel_hold_o,
	input wire logic run_decel_o,
	input wire logic decel_time_two_o,
	input wire logic freq_agree_o,
	input wire logic cmd_loss_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ctrl;
	logic [31:0] high_cnt;
	// shadow of the control register
	always_ff @(posedge mclk_i) begin
		if (reset_i)
			ctrl <= spfd_pkg::CTRL_RESET;
		else if (reg_wr_i && reg_addr_i == spfd_pkg::ADDR_CTRL)
			ctrl <= reg_wdata_i[7:0];
	end
	// length of the current run reduction
	always_ff @(posedge mclk_i) begin
		if (reset_i || !run_decel_o)
			high_cnt <= 32'h0;
		else
			high_cnt <= high_cnt + 32'h1;
	end
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);
	a_accel_phase: assert property (accel_hold_o |->
		$past(ramp_phase_i) == spfd_pkg::SPFD_ACCEL && $past(ctrl[0]))
		else $error("accel hold outside enabled accel phase");
	a_decel_phase: assert property (decel_hold_o |->
		$past(ramp_phase_i) == spfd_pkg::SPFD_DECEL && $past(ctrl[1]))
		else $error("decel hold outside enabled decel phase");
	a_run_floor: assert property (run_decel_o |->
		$past(out_freq_i) >= spfd_pkg::RUN_MIN_FREQ)
		else $error("run reduction below minimum frequency");
	a_run_mode: assert property (run_decel_o |->
		$past(ctrl[3] ^ ctrl[2]))
		else $error("run reduction with run stall off");
	a_run_start: assert property ($rose(run_decel_o) |->
		$past(ramp_phase_i) == spfd_pkg::SPFD_RUN)
		else $error("run reduction began outside run phase");
	a_time_sel: assert property (run_decel_o |->
		decel_time_two_o == $past(ctrl[3:2] == 2'b10))
		else $error("wrong deceleration time selected");
	a_recover_wait: assert property ($fell(run_decel_o) &&
		$past(ctrl[3] ^ ctrl[2]) && $past(out_freq_i) >= 16'h3C |->
		high_cnt >= RECOVER_CYCLES - 1)
		else $error("run reduction released too early");
	a_agree_idle: assert property (freq_agree_o |->
		$past(ramp_phase_i) != spfd_pkg::SPFD_IDLE)
		else $error("frequency agree while idle");
	a_target_cmd: assert property (!cmd_loss_o &&
		!$past(cmd_loss_o) && !$past(reset_i) |->
		freq_target_o == $past(freq_cmd_i))
		else $error("target does not follow command");
	c_accel: cover property ($rose(accel_hold_o));
	c_release: cover property ($fell(run_decel_o));
	c_loss: cover property ($rose(cmd_loss_o));
endmodule
bind spfd_core spfd_monitor #(.RECOVER_CYCLES(RECOVER_CYCLES)) u_monitor (
	.mclk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .ramp_phase_i,
	.out_freq_i, .freq_cmd_i, .freq_target_o, .accel_hold_o, .decel_hold_o,
	.run_decel_o, .decel_time_two_o, .freq_agree_o, .cmd_loss_o);
`default_nettype wire

/* verif/spfd_motor_model.sv */
// spfd_motor_model: power stage and measurement front end.
// assumes demands from the bench; readings land one clock later.
`default_nettype none
module spfd_motor_model (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// demanded operating point
	input wire logic [15:0] dem_freq_i,
	input wire logic [7:0] dem_current_i,
	input wire logic [9:0] dem_voltage_i,
	// measured values
	output logic [15:0] out_freq_o,
	output logic [7:0] out_current_o,
	output logic [9:0] bus_voltage_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// measurement sampled once per clock
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			out_freq_o <= 16'h0;
			out_current_o <= 8'h0;
			bus_voltage_o <= 10'h0;
		end else begin
			out_freq_o <= dem_freq_i;
			out_current_o <= dem_current_i;
			bus_voltage_o <= dem_voltage_i;
		end
	end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// tb_top: directed scenarios for the stall and frequency supervisor.
// assumes short recovery and millisecond counts set by parameter here.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RECOVER = 20;
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [1:0] ramp_phase_i = 2'b00;
	logic [15:0] freq_cmd_i = 16'h0;
	logic [7:0] analog_level_i = 8'h00;
	logic [15:0] dem_freq = 16'h0;
	logic [7:0] dem_cur = 8'h0;
	logic [9:0] dem_volt = 10'h0;
	logic [31:0] reg_rdata_o;
	logic [15:0] out_freq_i, freq_target_o;
	logic [7:0] out_current_i;
	logic [9:0] bus_voltage_i;
	logic accel_hold_o, decel_hold_o, run_decel_o, decel_time_two_o;
	logic freq_agree_o, user_freq_agree_o, freq_detect1_o, freq_detect2_o;
	logic cmd_loss_o;
	int errors = 0;
	int comparisons = 0;
	always #2 mclk_i = ~mclk_i;
	spfd_core #(.RECOVER_CYCLES(RECOVER), .MS_TICK_CYCLES(4)) u_dut (
		.mclk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .ramp_phase_i, .out_freq_i, .freq_cmd_i, .out_current_i,
		.bus_voltage_i, .analog_level_i, .freq_target_o, .accel_hold_o,
		.decel_hold_o, .run_decel_o, .decel_time_two_o, .freq_agree_o,
		.user_freq_agree_o, .freq_detect1_o, .freq_detect2_o, .cmd_loss_o);
	spfd_motor_model u_motor (.mclk_i, .reset_i, .dem_freq_i(dem_freq),
		.dem_current_i(dem_cur), .dem_voltage_i(dem_volt),
		.out_freq_o(out_freq_i), .out_current_o(out_current_i),
		.bus_voltage_o(bus_voltage_i));
	task automatic close_out();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(reg_rdata_o, exp);
	endtask
	// phase, frequency, current and voltage, then let them settle
	task automatic drive(input logic [1:0] ph, input logic [15:0] f,
		input logic [7:0] c, input logic [9:0] v);
		@(posedge mclk_i);
		ramp_phase_i <= ph;
		dem_freq <= f;
		dem_cur <= c;
		dem_volt <= v;
		repeat (3) @(posedge mclk_i);
		#1;
	endtask
	task automatic wait_loss(input logic v);
		for (int i = 0; i < 300 && cmd_loss_o !== v; i++)
			@(posedge mclk_i);
		#1;
		chk(cmd_loss_o, v);
	endtask
	task automatic t_regs();
		rd(spfd_pkg::ADDR_CTRL, 32'h07);
		rd(spfd_pkg::ADDR_DECEL, 32'h18B);
		rd(spfd_pkg::ADDR_FDET, 32'h0014012C);
		rd(spfd_pkg::ADDR_LOSS, 32'h00140320);
		rd(8'h24, 32'h0);
		wr(spfd_pkg::ADDR_DECEL, 32'h1F4);
		rd(spfd_pkg::ADDR_DECEL, 32'h19A);
		wr(spfd_pkg::ADDR_ACCEL, 32'hC8C8);
		rd(spfd_pkg::ADDR_ACCEL, 32'h6496);
		wr(spfd_pkg::ADDR_RUN, 32'h0A);
		rd(spfd_pkg::ADDR_RUN, 32'h1E);
		$display("test regs done");
	endtask
	task automatic t_accel();
		wr(spfd_pkg::ADDR_ACCEL, 32'h3264);
		drive(2'b01, 16'h64, 8'h65, 10'h12C);
		chk(accel_hold_o, 1'b1);
		drive(2'b01, 16'h64, 8'h56, 10'h12C);
		chk(accel_hold_o, 1'b1);
		drive(2'b01, 16'h64, 8'h54, 10'h12C);
		chk(accel_hold_o, 1'b0);
		drive(2'b01, 16'h4B0, 8'h3C, 10'h12C);
		chk(accel_hold_o, 1'b1);
		drive(2'b10, 16'h64, 8'h78, 10'h12C);
		chk(accel_hold_o, 1'b0);
		wr(spfd_pkg::ADDR_CTRL, 32'h06);
		drive(2'b01, 16'h64, 8'h78, 10'h12C);
		chk(accel_hold_o, 1'b0);
		$display("test accel done");
	endtask
	task automatic t_decel();
		wr(spfd_pkg::ADDR_CTRL, 32'h07);
		wr(spfd_pkg::ADDR_DECEL, 32'h18B);
		drive(2'b11, 16'h64, 8'h32, 10'h190);
		chk(decel_hold_o, 1'b1);
		drive(2'b11, 16'h64, 8'h32, 10'h186);
		chk(decel_hold_o, 1'b0);
		wr(spfd_pkg::ADDR_CTRL, 32'h27);
		drive(2'b11, 16'h64, 8'h32, 10'h190);
		chk(decel_hold_o, 1'b0);
		drive(2'b11, 16'h64, 8'h32, 10'h320);
		chk(decel_hold_o, 1'b1);
		wr(spfd_pkg::ADDR_CTRL, 32'h25);
		drive(2'b11, 16'h64, 8'h32, 10'h320);
		chk(decel_hold_o, 1'b0);
		$display("test decel done");
	endtask
	task automatic t_run();
		wr(spfd_pkg::ADDR_RUN, 32'h64);
		wr(spfd_pkg::ADDR_CTRL, 32'h05);
		drive(2'b10, 16'h64, 8'h78, 10'h12C);
		chk(run_decel_o, 1'b1);
		chk(decel_time_two_o, 1'b0);
		drive(2'b10, 16'h64, 8'h5A, 10'h12C);
		chk(run_decel_o, 1'b1);
		repeat (RECOVER + 4) @(posedge mclk_i);
		#1;
		chk(run_decel_o, 1'b0);
		wr(spfd_pkg::ADDR_CTRL, 32'h09);
		drive(2'b10, 16'h64, 8'h78, 10'h12C);
		chk(decel_time_two_o, 1'b1);
		drive(2'b10, 16'h32, 8'h78, 10'h12C);
		chk(run_decel_o, 1'b0);
		drive(2'b10, 16'h64, 8'h78, 10'h12C);
		wr(spfd_pkg::ADDR_CTRL, 32'h01);
		drive(2'b10, 16'h64, 8'h78, 10'h12C);
		chk(run_decel_o, 1'b0);
		analog_level_i <= 8'h3C;
		wr(spfd_pkg::ADDR_CTRL, 32'h45);
		drive(2'b10, 16'h64, 8'h50, 10'h12C);
		chk(run_decel_o, 1'b1);
		wr(spfd_pkg::ADDR_CTRL, 32'h01);
		$display("test run done");
	endtask
	task automatic t_fdet();
		freq_cmd_i <= 16'h12C;
		drive(2'b10, 16'hFA, 8'h0A, 10'h12C);
		chk(freq_detect1_o, 1'b0);
		chk(freq_detect2_o, 1'b1);
		chk(freq_agree_o, 1'b0);
		drive(2'b10, 16'h136, 8'h0A, 10'h12C);
		chk(freq_agree_o, 1'b1);
		chk(user_freq_agree_o, 1'b1);
		chk(freq_detect1_o, 1'b1);
		chk(freq_detect2_o, 1'b1);
		drive(2'b10, 16'h14A, 8'h0A, 10'h12C);
		chk(freq_detect2_o, 1'b0);
		chk(freq_agree_o, 1'b0);
		drive(2'b00, 16'h136, 8'h0A, 10'h12C);
		chk(freq_agree_o, 1'b0);
		$display("test detect done");
	endtask
	task automatic t_loss();
		freq_cmd_i <= 16'h1F4;
		drive(2'b10, 16'h1F4, 8'h0A, 10'h12C);
		repeat (200) @(posedge mclk_i);
		#1;
		chk(cmd_loss_o, 1'b0);
		freq_cmd_i <= 16'h64;
		wait_loss(1'b1);
		chk(freq_target_o, 16'h64);
		wr(spfd_pkg::ADDR_CTRL, 32'h11);
		repeat (3) @(posedge mclk_i);
		#1;
		chk(freq_target_o, 16'h1E0);
		freq_cmd_i <= 16'h1F4;
		wait_loss(1'b0);
		repeat (3) @(posedge mclk_i);
		#1;
		chk(freq_target_o, 16'h1F4);
		$display("test loss done");
	endtask
	initial begin
		#100us;
		errors++;
		$display("watchdog expired");
		close_out();
	end
	initial begin
		repeat (16) @(posedge mclk_i);
		reset_i <= 1'b0;
		t_regs();
		t_accel();
		t_decel();
		t_run();
		t_fdet();
		t_loss();
		close_out();
	end
endmodule
`default_nettype wire
